/* File: logic/cowm_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cowm_consts.svh"

module cowm_channel #(
  parameter bit CHAN_A = 1'b0
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              tick,
  input  wire logic [1:0]        action,
  input  wire cowm_pkg::cowm_kind_t kind,
  input  wire logic              mode_high,
  input  wire logic              match,
  input  wire logic              at_top,
  input  wire logic              count_up,
  input  wire logic              cmp_is_top,
  output logic                   wave,
  output logic                   drive_en
);

  logic pwm;
  logic toggle_ok;
  logic top_case;
  logic next_wave;

  assign pwm = (kind == cowm_pkg::COWM_FAST) ||
               (kind == cowm_pkg::COWM_PHASE);
  // Code 01 only toggles in PWM for channel A with the mode high bit set
  assign toggle_ok = !pwm || (CHAN_A && mode_high);
  // Match at TOP is ignored; level is forced at TOP instead
  assign top_case = pwm && action[1] && cmp_is_top;

  always_comb begin
    next_wave = wave;
    if (kind == cowm_pkg::COWM_RESV) begin
      next_wave = wave;
    end else if (action == `COWM_ACT_TOGGLE) begin
      if (toggle_ok && match) begin
        next_wave = !wave;
      end
    end else if (action[1] && !pwm) begin
      if (match) begin
        next_wave = action[0];
      end
    end else if (action[1] && top_case) begin
      if (tick && at_top) begin
        next_wave = !action[0];
      end
    end else if (action[1] && kind == cowm_pkg::COWM_FAST) begin
      if (match) begin
        next_wave = action[0];
      end else if (tick && at_top) begin
        next_wave = !action[0];
      end
    end else if (action[1]) begin
      if (match) begin
        next_wave = count_up ? action[0] : !action[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave <= 1'b0;
    end else if (ce) begin
      wave <= next_wave;
    end
  end

  // Pin override only; the port direction bit stays with software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_en <= 1'b0;
    end else if (ce) begin
      drive_en <= (action != `COWM_ACT_OFF) &&
                  (kind != cowm_pkg::COWM_RESV) &&
                  (action != `COWM_ACT_TOGGLE || toggle_ok);
    end
  end

endmodule

// Summary of operation
// - Nonzero channel A action field makes wave output A own its pin, except in modes 4 and 6 and for PWM code 01 with mode high bit 0.
// - Non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match.
// - PWM channel A code 01: off if mode high bit 0, else toggle.
// - Fast PWM A: 10 clears on match, sets at BOTTOM; 11 the inverse.
// - Phase correct A: 10 clears on up match, sets on down match; 11 opposite.
// - PWM with compare equal TOP and action high bit: act at TOP instead.
// - Nonzero channel B action field makes wave output B own its pin, except in modes 4 and 6 and for PWM code 01.
// - Non-PWM channel B: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM B: 01 reserved, 10 clear/BOTTOM set, 11 inverse.
// - Phase correct B: 01 reserved, 10 clear up/set down, 11 reverse.
// - Control register A bits 3 and 2 always read zero.
// - Mode is control A bits 1:0 plus a high bit held elsewhere.
// - Modes 0-3: normal, phase correct, clear-on-match, fast PWM as tabled.
// - Modes 4,6 reserved; 5 phase correct and 7 fast, TOP from compare A.
// - Mode high bit lives at bit 3 of control register B.
// - Overflow flag set on overflow; in phase correct at turn at zero.
module cowm_top (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic                      count_tick,
  input  wire logic [7:0]                compare_value_a,
  input  wire logic [7:0]                compare_value_b,
  input  wire logic [`COWM_ADDR_W-1:0]   bus_addr,
  input  wire logic [7:0]                bus_wdata,
  input  wire logic                      bus_write,
  input  wire logic                      bus_read,
  output logic [7:0]                     bus_rdata,
  output logic                           wave_out_a,
  output logic                           wave_out_a_en,
  output logic                           wave_out_b,
  output logic                           wave_out_b_en,
  output logic                           irq
);

  logic [7:0]           ctrl_a;
  logic                 wave_mode_high_bit;
  logic [2:0]           status;
  logic [2:0]           mask;
  logic [7:0]           count;
  logic                 count_up;
  logic [7:0]           cmp_a;
  logic [7:0]           cmp_b;
  logic [2:0]           wave_mode_select;
  logic [7:0]           top;
  logic                 at_top;
  logic                 at_bottom;
  logic                 tick;
  logic                 match_a;
  logic                 match_b;
  logic                 overflow_flag;
  logic                 load_cmp;
  logic [2:0]           events;
  logic [7:0]           next_count;
  logic                 next_up;
  cowm_pkg::cowm_kind_t kind;

  assign wave_mode_select = {wave_mode_high_bit,
                             ctrl_a[`COWM_MODE_LO_HI:`COWM_MODE_LO_LO]};

  always_comb begin
    unique case (wave_mode_select)
      3'h0:    kind = cowm_pkg::COWM_NORMAL;
      3'h1:    kind = cowm_pkg::COWM_PHASE;
      3'h2:    kind = cowm_pkg::COWM_CLEAR_MATCH;
      3'h3:    kind = cowm_pkg::COWM_FAST;
      3'h5:    kind = cowm_pkg::COWM_PHASE;
      3'h7:    kind = cowm_pkg::COWM_FAST;
      3'h4:    kind = cowm_pkg::COWM_RESV;
      3'h6:    kind = cowm_pkg::COWM_RESV;
    endcase
  end

  // TOP from compare A in modes 2, 5 and 7, else fixed at MAX
  assign top = (wave_mode_select == 3'h2 || wave_mode_select == 3'h5 ||
                wave_mode_select == 3'h7) ? cmp_a : `COWM_MAX;
  assign at_top    = (count == top);
  assign at_bottom = (count == `COWM_BOTTOM);
  assign tick      = count_tick;

  // Counter sequence
  always_comb begin
    next_count = count;
    next_up    = count_up;
    if (kind == cowm_pkg::COWM_PHASE) begin
      if (count_up && at_top) begin
        next_up    = 1'b0;
        next_count = count - 8'h01;
      end else if (!count_up && at_bottom) begin
        next_up    = 1'b1;
        next_count = count + 8'h01;
      end else begin
        next_count = count_up ? count + 8'h01 : count - 8'h01;
      end
    end else begin
      next_up    = 1'b1;
      next_count = at_top ? `COWM_BOTTOM : count + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count    <= `COWM_BOTTOM;
      count_up <= 1'b1;
    end else if (ce && tick) begin
      count    <= next_count;
      count_up <= next_up;
    end
  end

  // Compare buffering: immediate, at TOP or at BOTTOM by mode
  always_comb begin
    unique case (kind)
      cowm_pkg::COWM_PHASE: load_cmp = tick && count_up && at_top;
      cowm_pkg::COWM_FAST:  load_cmp = tick && at_top;
      default:              load_cmp = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a <= `COWM_BOTTOM;
      cmp_b <= `COWM_BOTTOM;
    end else if (ce && load_cmp) begin
      cmp_a <= compare_value_a;
      cmp_b <= compare_value_b;
    end
  end

  assign match_a = tick && (count == cmp_a);
  assign match_b = tick && (count == cmp_b);

  // Overflow event placement per mode
  always_comb begin
    if (kind == cowm_pkg::COWM_PHASE) begin
      overflow_flag = tick && !count_up && at_bottom;
    end else if (wave_mode_select == 3'h7) begin
      overflow_flag = tick && at_top;
    end else begin
      overflow_flag = tick && (count == `COWM_MAX);
    end
  end

  assign events = {match_b, match_a, overflow_flag};

  cowm_channel #(
    .CHAN_A (1'b1)
  ) u_chan_a (
    .clk        (clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .tick       (tick),
    .action     (ctrl_a[`COWM_A_ACT_HI:`COWM_A_ACT_LO]),
    .kind       (kind),
    .mode_high  (wave_mode_high_bit),
    .match      (match_a),
    .at_top     (at_top),
    .count_up   (count_up),
    .cmp_is_top (cmp_a == top),
    .wave       (wave_out_a),
    .drive_en   (wave_out_a_en)
  );

  cowm_channel #(
    .CHAN_A (1'b0)
  ) u_chan_b (
    .clk        (clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .tick       (tick),
    .action     (ctrl_a[`COWM_B_ACT_HI:`COWM_B_ACT_LO]),
    .kind       (kind),
    .mode_high  (wave_mode_high_bit),
    .match      (match_b),
    .at_top     (at_top),
    .count_up   (count_up),
    .cmp_is_top (cmp_b == top),
    .wave       (wave_out_b),
    .drive_en   (wave_out_b_en)
  );

  // Control registers; reserved bits never store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a <= `COWM_CTRL_A_RESET;
    end else if (ce && bus_write && bus_addr == `COWM_REG_CTRL_A) begin
      ctrl_a <= bus_wdata & `COWM_CTRL_A_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_mode_high_bit <= `COWM_CTRL_B_RESET;
    end else if (ce && bus_write && bus_addr == `COWM_REG_CTRL_B) begin
      wave_mode_high_bit <= bus_wdata[`COWM_MODE_HIGH_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= `COWM_ST_RESET;
    end else if (ce && bus_write && bus_addr == `COWM_REG_MASK) begin
      mask <= bus_wdata[2:0];
    end
  end

  // Read clears; an event in the same cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= `COWM_ST_RESET;
    end else if (ce) begin
      if (bus_read && bus_addr == `COWM_REG_STATUS) begin
        status <= events;
      end else begin
        status <= status | events;
      end
    end
  end

  assign irq = |(status & mask);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (ce) begin
      bus_rdata <= 8'h00;
      if (bus_read) begin
        unique case (bus_addr)
          `COWM_REG_CTRL_A: bus_rdata <= ctrl_a;
          `COWM_REG_CTRL_B: bus_rdata <= {4'h0, wave_mode_high_bit, 3'h0};
          `COWM_REG_STATUS: bus_rdata <= {5'h00, status};
          `COWM_REG_MASK:   bus_rdata <= {5'h00, mask};
          `COWM_REG_COUNT:  bus_rdata <= count;
          default:          bus_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* File: logic/cowm_consts.svh */
`ifndef COWM_CONSTS_SVH
`define COWM_CONSTS_SVH

// Register indices on the plain register port
`define COWM_ADDR_W          3
`define COWM_REG_CTRL_A      3'h0
`define COWM_REG_CTRL_B      3'h1
`define COWM_REG_STATUS      3'h2
`define COWM_REG_MASK        3'h3
`define COWM_REG_COUNT       3'h4

// Control register A fields
`define COWM_A_ACT_HI        7
`define COWM_A_ACT_LO        6
`define COWM_B_ACT_HI        5
`define COWM_B_ACT_LO        4
`define COWM_MODE_LO_HI      1
`define COWM_MODE_LO_LO      0
`define COWM_CTRL_A_WMASK    8'hF3
`define COWM_CTRL_A_RESET    8'h00

// Control register B field
`define COWM_MODE_HIGH_BIT   3
`define COWM_CTRL_B_RESET    1'b0

// Status and mask bits
`define COWM_ST_OVF          0
`define COWM_ST_MATCH_A      1
`define COWM_ST_MATCH_B      2
`define COWM_ST_RESET        3'h0

// Counter limits
`define COWM_MAX             8'hFF
`define COWM_BOTTOM          8'h00

// Action codes
`define COWM_ACT_OFF         2'h0
`define COWM_ACT_TOGGLE      2'h1
`define COWM_ACT_CLEAR       2'h2
`define COWM_ACT_SET         2'h3

`endif

/* File: logic/cowm_pkg.sv */
package cowm_pkg;

  typedef enum logic [2:0] {
    COWM_NORMAL,
    COWM_PHASE,
    COWM_CLEAR_MATCH,
    COWM_FAST,
    COWM_RESV
  } cowm_kind_t;

endpackage

/* File: dv/cowm_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cowm_consts.svh"
module cowm_chk (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  input  wire logic                    count_tick,
  input  wire logic [`COWM_ADDR_W-1:0] bus_addr,
  input  wire logic [7:0]              bus_wdata,
  input  wire logic                    bus_write,
  input  wire logic                    bus_read,
  input  wire logic [7:0]              bus_rdata,
  input  wire logic                    wave_out_a,
  input  wire logic                    wave_out_a_en,
  input  wire logic                    wave_out_b,
  input  wire logic                    wave_out_b_en,
  input  wire logic                    irq
);
  logic [7:0] ctl_a;
  logic       mode_hi;
  logic [2:0] mask;
  logic       en_a;
  logic       en_b;
  wire  [2:0] md = {mode_hi, ctl_a[1:0]};
  wire        rs = (md == 3'h4) || (md == 3'h6);
  // Odd modes are the PWM ones
  wire        pw = md[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_a <= 8'h00;
      mode_hi <= 1'b0;
      mask <= 3'h0;
    end else if (ce && bus_write) begin
      if (bus_addr == `COWM_REG_CTRL_A) ctl_a <= bus_wdata & 8'hF3;
      if (bus_addr == `COWM_REG_CTRL_B) mode_hi <= bus_wdata[3];
      if (bus_addr == `COWM_REG_MASK) mask <= bus_wdata[2:0];
    end
  end

  // Override lags the register by one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_a <= 1'b0;
      en_b <= 1'b0;
    end else if (ce) begin
      en_a <= !rs && ctl_a[7:6] != 2'h0
              && (!pw || ctl_a[7:6] != 2'h1 || mode_hi);
      en_b <= !rs && ctl_a[5:4] != 2'h0 && (!pw || ctl_a[5:4] != 2'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_en_a_map: assert property (wave_out_a_en == en_a)
    else $error("pin override A wrong");
  chk_en_b_map: assert property (wave_out_b_en == en_b)
    else $error("pin override B wrong");
  chk_rd_idle: assert property (ce && !bus_read |=> bus_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_ctl_read: assert property (ce && bus_read && bus_addr == 3'h0
    |=> bus_rdata == $past(ctl_a)) else $error("control A readback");
  chk_hi_read: assert property (ce && bus_read && bus_addr == 3'h1
    |=> bus_rdata == {4'h0, $past(mode_hi), 3'h0})
    else $error("control B readback");
  chk_unmapped_zero: assert property (ce && bus_read && bus_addr > 3'h4
    |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  chk_wave_idle: assert property (ce && !count_tick
    |=> $stable(wave_out_a) && $stable(wave_out_b))
    else $error("wave moved without a step");
  chk_rsv_frozen: assert property (ce && rs
    |=> $stable(wave_out_a) && $stable(wave_out_b))
    else $error("wave moved in reserved mode");
  chk_irq_masked: assert property (mask == 3'h0 |-> !irq)
    else $error("interrupt while all masked");
endmodule
`default_nettype wire

/* File: dv/cowm_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cowm_pin_model (
  input  wire logic wave,
  input  wire logic drive_en,
  input  wire logic dir_out,
  output logic      pin
);
  // Pull-up holds the pin while the driver is off
  assign pin = (drive_en && dir_out) ? wave : 1'b1;
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cowm_consts.svh"
module tb;
  logic        clk, rst_n, ce, count_tick, bus_write, bus_read;
  logic [7:0]  cmp_a, cmp_b, bus_wdata, rd, cnt, ra, rb;
  logic [2:0]  bus_addr;
  logic [31:0] lfsr;
  logic [6:0]  v;
  logic        dir_a, dir_b;
  wire  [7:0]  bus_rdata;
  wire         wa, wae, wb, wbe, irq, pin_a, pin_b;
  int          err_count, total_checks;
  int          cycles = 0;

  cowm_top dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
    .count_tick(count_tick), .compare_value_a(cmp_a),
    .compare_value_b(cmp_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .wave_out_a(wa), .wave_out_a_en(wae), .wave_out_b(wb),
    .wave_out_b_en(wbe), .irq(irq));
  cowm_pin_model pa_u (.wave(wa), .drive_en(wae), .dir_out(dir_a),
    .pin(pin_a));
  cowm_pin_model pb_u (.wave(wb), .drive_en(wbe), .dir_out(dir_b),
    .pin(pin_b));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic exp_en(input logic [2:0] m, input logic [1:0] c,
                                  input logic is_a);
    if (m == 3'h4 || m == 3'h6 || c == 2'h0) return 1'b0;
    if (m[0] && c == 2'h1) return is_a && m[2];
    return 1'b1;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clk);
    bus_write <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clk);
    bus_read <= 1'b0;
    #1 rd = bus_rdata;
  endtask

  // Count tracking holds only while counting up
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk);
      count_tick <= 1'b1;
    end
    @(posedge clk);
    count_tick <= 1'b0;
    cnt = cnt + n[7:0];
    #1;
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    cnt = 8'h00;
  endtask

  task automatic conclude;
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    {rst_n, ce, count_tick, bus_write, bus_read} = 5'h08;
    {cmp_a, cmp_b, bus_wdata, bus_addr} = 27'h0;
    {dir_a, dir_b} = 2'h3;
    lfsr = 32'h00012D70;
    err_count = 0;
    total_checks = 0;
    do_reset();
    chk({3'h0, wa, wae, wb, wbe, irq}, 8'h00);
    for (int a = 0; a < 6; a++) begin
      rd_reg(a[2:0]);
      chk(rd, 8'h00);
    end
    wr(`COWM_REG_CTRL_A, 8'hFF);
    rd_reg(`COWM_REG_CTRL_A);
    chk(rd, 8'hF3);
    wr(`COWM_REG_CTRL_B, 8'hFF);
    rd_reg(`COWM_REG_CTRL_B);
    chk(rd, 8'h08);
    for (int i = 0; i < 128; i++) begin
      v = i[6:0];
      wr(`COWM_REG_CTRL_B, {4'h0, v[6], 3'h0});
      wr(`COWM_REG_CTRL_A, {v[3:0], 2'h0, v[5:4]});
      @(posedge clk);
      #1 chk({6'h0, wae, wbe}, {6'h0, exp_en(v[6:4], v[3:2], 1'b1),
             exp_en(v[6:4], v[1:0], 1'b0)});
    end
    lfsr = nxt(lfsr);
    ra = {1'b0, lfsr[6:0]} | 8'h01;
    rb = ra + {4'h0, lfsr[11:8]} + 8'h01;
    cmp_a <= ra;
    cmp_b <= rb;
    wr(`COWM_REG_CTRL_B, 8'h00);
    wr(`COWM_REG_CTRL_A, 8'h70);
    tk(ra);
    chk({6'h0, wa, wb}, 8'h00);
    tk(1);
    chk({6'h0, wa, wb}, 8'h02);
    tk(rb - ra);
    chk({6'h0, wa, wb}, 8'h03);
    tk(256);
    chk({6'h0, wa, wb}, 8'h01);
    rd_reg(`COWM_REG_COUNT);
    chk(rd, cnt);
    chk({7'h0, irq}, 8'h00);
    rd_reg(`COWM_REG_STATUS);
    chk(rd, 8'h07);
    rd_reg(`COWM_REG_STATUS);
    chk(rd, 8'h00);
    wr(`COWM_REG_CTRL_A, 8'hB3);
    tk(256 - cnt);
    chk({6'h0, wa, wb}, 8'h02);
    tk(ra + 1);
    chk({6'h0, wa, wb}, 8'h00);
    chk({7'h0, pin_a}, 8'h00);
    dir_a <= 1'b0;
    tk(rb - ra);
    chk({6'h0, wa, wb}, 8'h01);
    chk({7'h0, pin_a}, 8'h01);
    cmp_a <= 8'hFF;
    tk(256 - cnt);
    for (int i = 0; i < 256; i++) begin
      tk(1);
      chk({7'h0, wa}, 8'h01);
    end
    @(posedge clk);
    ce <= 1'b0;
    tk(3);
    ce <= 1'b1;
    rd_reg(`COWM_REG_COUNT);
    chk(rd, cnt - 8'h03);
    cmp_a <= ra;
    do_reset();
    wr(`COWM_REG_MASK, 8'h01);
    wr(`COWM_REG_CTRL_A, 8'hA1);
    tk(510 - ra);
    chk({6'h0, wa, wb}, 8'h01);
    tk(1);
    chk({6'h0, wa, wb}, 8'h03);
    chk({7'h0, irq}, 8'h00);
    tk(ra + 1);
    chk({7'h0, irq}, 8'h01);
    rd_reg(`COWM_REG_STATUS);
    chk({7'h0, rd[0]}, 8'h01);
    chk({7'h0, irq}, 8'h00);
    // Clear-on-match: TOP from compare A, no overflow below MAX
    do_reset();
    wr(`COWM_REG_CTRL_A, 8'h52);
    tk(ra + 1);
    chk({6'h0, wa, wb}, 8'h02);
    rd_reg(`COWM_REG_COUNT);
    chk(rd, 8'h00);
    rd_reg(`COWM_REG_STATUS);
    chk(rd, 8'h02);
    // Mode 7: fast PWM wraps and flags overflow at compare A
    wr(`COWM_REG_CTRL_B, 8'h08);
    wr(`COWM_REG_CTRL_A, 8'h03);
    tk(ra + 1);
    rd_reg(`COWM_REG_COUNT);
    chk(rd, 8'h00);
    rd_reg(`COWM_REG_STATUS);
    chk(rd, 8'h03);
    conclude();
  end
endmodule

bind cowm_top cowm_chk chk_u (.clk(clk), .rst_n(rst_n), .ce(ce),
  .count_tick(count_tick), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
  .wave_out_a(wave_out_a), .wave_out_a_en(wave_out_a_en),
  .wave_out_b(wave_out_b), .wave_out_b_en(wave_out_b_en), .irq(irq));
`default_nettype wire
